// ---- design/power_mode_regs.vh ----
/*
  Constants of the power-mode sequencer: register offsets, field positions,
  reset values, mode codes and settling counts.
  Assumes inclusion by bare name from the sequencer sources.
*/
// Notes on behaviour
// - Halt in active, standby_select 0: sleep
// - Sleep keeps oscillator, irq zero/one, timer A
// - Accepted irq or timer A leaves sleep
// - No wake while masked or source disabled
// - Reset pin low in sleep resets CPU
// - Halt, standby_select 1, watch 0: standby
// - Standby/subactive: ports high-Z, PMOS off
// - Irq in standby: restart, settle, exception
// - Reset pin low leaves deep modes
// - Halt, standby_select 1, watch 1: watch
// - Halt in subactive, direct 0: watch
// - Watch: timer A runs on subclock, irq pins stay on
// - Watch wake, low_speed 0: settle, active
// - Watch wake, low_speed 1: go subactive
// - Subactive: CPU on subclock, outputs reset
// - Halt always leaves subactive
// - Direct transfer: interrupt, settle, active
// - Direct transfer blocked when masked/disabled
// - Settle codes: 8192..65536, top bit 131072
// - standby_select stays set; write only active
// - direct_transfer_select writable only subactive
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH

`define PCTL_ONE_OFFSET 4'h0
`define PCTL_TWO_OFFSET 4'h4
`define MODE_STATUS_OFFSET 4'h8
`define PCTL_ONE_RESET 8'h00
`define PCTL_TWO_RESET 8'hf4
`define PCTL_ONE_SSEL_BIT 7
`define PCTL_ONE_WAIT_HI 6
`define PCTL_ONE_WAIT_LO 4
`define PCTL_ONE_LSEL_BIT 3
`define PCTL_ONE_WMASK 8'hfc
`define PCTL_TWO_DTS_BIT 3
`define PCTL_TWO_WMASK 8'h0b

`define MODE_ACTIVE 3'd0
`define MODE_SLEEP 3'd1
`define MODE_STANDBY 3'd2
`define MODE_WATCH 3'd3
`define MODE_SUBACTIVE 3'd4
`define MODE_SETTLE 3'd5

`define SETTLE_WAIT_0 18'd8192
`define SETTLE_WAIT_1 18'd16384
`define SETTLE_WAIT_2 18'd32768
`define SETTLE_WAIT_3 18'd65536
`define SETTLE_WAIT_4 18'd131072

`endif

// ---- design/settle_counter.v ----
/*
  Oscillator settling down-counter. Loads a count on start and pulses done
  when it reaches zero. Assumes it runs on the restarted main clock.
*/
`timescale 1ns/100ps
`default_nettype none
module settle_counter (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire abort,
  input wire [17:0] load_value,
  output reg busy,
  output reg done
);
  reg [17:0] count;

  // Count down to zero, then report once
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= 18'h0_0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        // Two edges go to loading and to the done pulse, so the mode holds N+1 cycles
        count <= load_value - 18'd2;
        busy <= 1'b1;
      end else if (busy) begin
        if (count == 18'h0_0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 18'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/power_mode_sequencer.v ----
/*
  Power-mode sequencer: mode state machine, AXI4-Lite register slave for the
  two power control registers and a mode status word.
  Assumes halt and interrupt requests come from same-clock CPU logic; the
  reset pin and irq pins come from outside and are synchronised here.
*/
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "power_mode_regs.vh"
module power_mode_sequencer (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire halt_exec,
  input wire timebase_watch_select,
  input wire interrupt_mask_flag,
  input wire irq_zero_enable,
  input wire irq_one_enable,
  input wire timer_a_enable,
  input wire direct_irq_enable,
  input wire ext_irq_zero,
  input wire ext_irq_one,
  input wire timer_a_request,
  input wire external_reset_n,
  output reg main_osc_enable,
  output reg cpu_clock_enable,
  output reg cpu_on_subclock,
  output reg cpu_reset,
  output reg peripheral_enable,
  output reg timer_a_run,
  output reg ext_irq_run,
  output reg peripheral_out_reset,
  output reg ports_high_z,
  output reg pmos_off,
  output reg irq_exception_start,
  output reg direct_transfer_irq,
  output reg [2:0] mode
);
  reg [7:0] power_control_one;
  reg [7:0] power_control_two;
  reg [2:0] settle_target;
  reg settle_by_reset;
  reg rst_meta, rst_sync, rst_prev;
  reg ext_irq_zero_meta, ext_irq_zero_sync, ext_irq_one_meta, ext_irq_one_sync;
  reg [17:0] next_wait;
  reg settle_start;
  reg settle_abort;
  wire settle_busy;
  wire settle_done;
  reg aw_held, w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire standby_select = power_control_one[`PCTL_ONE_SSEL_BIT];
  wire [2:0] settle_wait_select = power_control_one[`PCTL_ONE_WAIT_HI:`PCTL_ONE_WAIT_LO];
  wire low_speed_select = power_control_one[`PCTL_ONE_LSEL_BIT];
  wire direct_transfer_select = power_control_two[`PCTL_TWO_DTS_BIT];

  // Two-stage synchronisers for pins; first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
      rst_prev <= 1'b1;
      ext_irq_zero_meta <= 1'b0;
      ext_irq_zero_sync <= 1'b0;
      ext_irq_one_meta <= 1'b0;
      ext_irq_one_sync <= 1'b0;
    end else begin
      rst_meta <= external_reset_n;
      rst_sync <= rst_meta;
      rst_prev <= rst_sync;
      ext_irq_zero_meta <= ext_irq_zero;
      ext_irq_zero_sync <= ext_irq_zero_meta;
      ext_irq_one_meta <= ext_irq_one;
      ext_irq_one_sync <= ext_irq_one_meta;
    end
  end

  // Wake qualification: mask flag and per-source enables gate every wake
  wire ext_irq_zero_ok = ext_irq_zero_sync && irq_zero_enable && !interrupt_mask_flag;
  wire ext_irq_one_ok = ext_irq_one_sync && irq_one_enable && !interrupt_mask_flag;
  wire tma_ok = timer_a_request && timer_a_enable && !interrupt_mask_flag;
  wire direct_ok = direct_irq_enable && !interrupt_mask_flag;
  wire reset_pin_low = !rst_sync;

  // Settling length from the select code; any code with top bit set is longest
  always @* begin
    case (settle_wait_select)
      3'd0: next_wait = `SETTLE_WAIT_0;
      3'd1: next_wait = `SETTLE_WAIT_1;
      3'd2: next_wait = `SETTLE_WAIT_2;
      3'd3: next_wait = `SETTLE_WAIT_3;
      default: next_wait = `SETTLE_WAIT_4;
    endcase
  end

  settle_counter settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(settle_start),
    .abort(settle_abort),
    .load_value(next_wait),
    .busy(settle_busy),
    .done(settle_done)
  );

  // Mode state machine; reset pin always wins over interrupt wakes
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `MODE_ACTIVE;
      settle_target <= `MODE_ACTIVE;
      settle_by_reset <= 1'b0;
      settle_start <= 1'b0;
      settle_abort <= 1'b0;
      irq_exception_start <= 1'b0;
      direct_transfer_irq <= 1'b0;
      cpu_reset <= 1'b0;
    end else begin
      settle_start <= 1'b0;
      settle_abort <= 1'b0;
      irq_exception_start <= 1'b0;
      direct_transfer_irq <= 1'b0;
      if (cpu_reset && !reset_pin_low && mode == `MODE_ACTIVE) begin
        cpu_reset <= 1'b0;
      end
      case (mode)
        `MODE_ACTIVE: begin
          if (halt_exec && !cpu_reset) begin
            if (!standby_select) begin
              mode <= `MODE_SLEEP;
            end else if (!timebase_watch_select) begin
              mode <= `MODE_STANDBY;
            end else begin
              mode <= `MODE_WATCH;
            end
          end
        end
        `MODE_SLEEP: begin
          if (reset_pin_low) begin
            cpu_reset <= 1'b1;
            mode <= `MODE_ACTIVE;
          end else if (ext_irq_zero_ok || ext_irq_one_ok || tma_ok) begin
            irq_exception_start <= 1'b1;
            mode <= `MODE_ACTIVE;
          end
        end
        `MODE_STANDBY: begin
          if (reset_pin_low) begin
            cpu_reset <= 1'b1;
            mode <= `MODE_ACTIVE;
          end else if (ext_irq_zero_ok || ext_irq_one_ok) begin
            settle_start <= 1'b1;
            settle_target <= `MODE_ACTIVE;
            settle_by_reset <= 1'b0;
            mode <= `MODE_SETTLE;
          end
        end
        `MODE_WATCH: begin
          if (reset_pin_low) begin
            cpu_reset <= 1'b1;
            mode <= `MODE_ACTIVE;
          end else if (ext_irq_zero_ok || tma_ok) begin
            if (low_speed_select) begin
              irq_exception_start <= 1'b1;
              mode <= `MODE_SUBACTIVE;
            end else begin
              settle_start <= 1'b1;
              settle_target <= `MODE_ACTIVE;
              settle_by_reset <= 1'b0;
              mode <= `MODE_SETTLE;
            end
          end
        end
        `MODE_SUBACTIVE: begin
          if (reset_pin_low) begin
            cpu_reset <= 1'b1;
            mode <= `MODE_ACTIVE;
          end else if (halt_exec) begin
            if (!direct_transfer_select || low_speed_select || !direct_ok) begin
              mode <= `MODE_WATCH;
            end else begin
              direct_transfer_irq <= 1'b1;
              settle_start <= 1'b1;
              settle_target <= `MODE_ACTIVE;
              settle_by_reset <= 1'b1;
              mode <= `MODE_SETTLE;
            end
          end
        end
        `MODE_SETTLE: begin
          if (reset_pin_low) begin
            settle_abort <= 1'b1;
            cpu_reset <= 1'b1;
            mode <= `MODE_ACTIVE;
          end else if (settle_done) begin
            mode <= settle_target;
            irq_exception_start <= !settle_by_reset;
          end
        end
        default: mode <= `MODE_ACTIVE;
      endcase
    end
  end

  // Gating outputs per mode; the oscillator runs through settling
  always @(posedge aclk) begin
    if (!aresetn) begin
      main_osc_enable <= 1'b1;
      cpu_clock_enable <= 1'b1;
      cpu_on_subclock <= 1'b0;
      peripheral_enable <= 1'b1;
      timer_a_run <= 1'b1;
      ext_irq_run <= 1'b1;
      peripheral_out_reset <= 1'b0;
      ports_high_z <= 1'b0;
      pmos_off <= 1'b0;
    end else begin
      main_osc_enable <= (mode == `MODE_ACTIVE) || (mode == `MODE_SLEEP) || (mode == `MODE_SETTLE);
      cpu_clock_enable <= (mode == `MODE_ACTIVE) || (mode == `MODE_SUBACTIVE);
      cpu_on_subclock <= (mode == `MODE_SUBACTIVE);
      peripheral_enable <= (mode == `MODE_ACTIVE);
      timer_a_run <= (mode != `MODE_STANDBY) && (mode != `MODE_SETTLE);
      ext_irq_run <= (mode != `MODE_SETTLE);
      peripheral_out_reset <= (mode != `MODE_ACTIVE) && (mode != `MODE_SETTLE);
      ports_high_z <= (mode == `MODE_STANDBY) || (mode == `MODE_SUBACTIVE) || (mode == `MODE_WATCH);
      pmos_off <= (mode == `MODE_STANDBY) || (mode == `MODE_SUBACTIVE) || (mode == `MODE_WATCH);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire write_go = aw_held && w_held && !s_axi_bvalid;
  wire [7:0] byte0 = w_strb[0] ? w_data[7:0] : 8'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      power_control_one <= `PCTL_ONE_RESET;
      power_control_two <= `PCTL_TWO_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (write_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        // Writes to power control two outside subactive are dropped silently, answer still OKAY
        if (aw_addr[3:2] == `PCTL_ONE_OFFSET >> 2) begin
          if (w_strb[0] && mode == `MODE_ACTIVE) begin
            power_control_one <= byte0 & `PCTL_ONE_WMASK;
          end else if (w_strb[0]) begin
            // Outside active only standby_select is frozen; low speed must clear in subactive
            power_control_one <= {power_control_one[7], byte0[6:2], 2'b00};
          end
        end else if (aw_addr[3:2] == `PCTL_TWO_OFFSET >> 2) begin
          if (w_strb[0] && mode == `MODE_SUBACTIVE) begin
            power_control_two <= (`PCTL_TWO_RESET & ~`PCTL_TWO_WMASK) | (byte0 & `PCTL_TWO_WMASK);
          end
        end else if (aw_addr[3:2] == `MODE_STATUS_OFFSET >> 2) begin
          s_axi_bresp <= 2'b10;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end
    end
  end

  // AXI4-Lite read; one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr[3:2] == `PCTL_ONE_OFFSET >> 2) begin
        s_axi_rdata <= {24'h00_0000, power_control_one};
      end else if (s_axi_araddr[3:2] == `PCTL_TWO_OFFSET >> 2) begin
        s_axi_rdata <= {24'h00_0000, power_control_two};
      end else if (s_axi_araddr[3:2] == `MODE_STATUS_OFFSET >> 2) begin
        s_axi_rdata <= {27'h000_0000, settle_busy, cpu_reset, mode[2:0]} & 32'h0000_001f;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- test/power_mode_sequencer_assertions.sv ----
/*
  Checker for the power-mode sequencer ports: mode entry, clock gating per
  mode, wake acceptance, settling length and reset-pin exit.
  Assumes one clock, aclk, and synchronous active-low aresetn; bound by name.
*/
`timescale 1ns/100ps
`default_nettype none
module power_mode_sequencer_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic halt_exec,
  input wire logic timebase_watch_select,
  input wire logic interrupt_mask_flag,
  input wire logic direct_irq_enable,
  input wire logic external_reset_n,
  input wire logic main_osc_enable,
  input wire logic cpu_on_subclock,
  input wire logic cpu_reset,
  input wire logic peripheral_enable,
  input wire logic timer_a_run,
  input wire logic ext_irq_run,
  input wire logic peripheral_out_reset,
  input wire logic ports_high_z,
  input wire logic pmos_off,
  input wire logic irq_exception_start,
  input wire logic direct_transfer_irq,
  input wire logic [2:0] mode
);
  int stay;
  // Settling length, read one edge after the exit
  always @(posedge aclk) begin
    if (!aresetn || mode != 3'h5) stay <= 0;
    else stay <= stay + 1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_halt_entry;
    halt_exec && mode == 3'h0 && !cpu_reset |=> mode == 3'h1 ||
      mode == ($past(timebase_watch_select) ? 3'h3 : 3'h2);
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("wrong mode after halt");
  property p_sleep_run;
    mode == 3'h1 |=> main_osc_enable && timer_a_run && ext_irq_run;
  endproperty
  a_sleep_run: assert property (p_sleep_run) else $error("sleep stopped a clock");
  property p_ports_off;
    mode == 3'h2 || mode == 3'h4 |=> ports_high_z && pmos_off && !main_osc_enable;
  endproperty
  a_ports_off: assert property (p_ports_off) else $error("ports still driven");
  property p_watch_clk;
    mode == 3'h3 |=> !main_osc_enable && timer_a_run && !peripheral_enable;
  endproperty
  a_watch_clk: assert property (p_watch_clk) else $error("watch gating wrong");
  property p_sub_clk;
    mode == 3'h4 |=> cpu_on_subclock && peripheral_out_reset && !main_osc_enable;
  endproperty
  a_sub_clk: assert property (p_sub_clk) else $error("subactive gating wrong");
  property p_sleep_wake;
    $past(mode) == 3'h1 && mode == 3'h0 && !cpu_reset |-> irq_exception_start && !$past(interrupt_mask_flag);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("bad sleep wake");
  property p_settle_len;
    $past(mode) == 3'h5 && mode == 3'h0 && !cpu_reset |-> stay == 32'h0000_2001 || stay == 32'h0000_4001
      || stay == 32'h0000_8001 || stay == 32'h0001_0001 || stay == 32'h0002_0001;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settling length wrong");
  property p_reset_pin;
    $fell(external_reset_n) && mode != 3'h0 |-> ##[1:4] (mode == 3'h0 && cpu_reset);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin not obeyed");
  property p_sub_halt;
    halt_exec && mode == 3'h4 |=> mode == 3'h3 || mode == 3'h5;
  endproperty
  a_sub_halt: assert property (p_sub_halt) else $error("halt kept subactive");
  property p_direct;
    direct_transfer_irq |-> $past(mode) == 3'h4 && !$past(interrupt_mask_flag) && $past(direct_irq_enable);
  endproperty
  a_direct: assert property (p_direct) else $error("direct transfer not allowed");
  c_sleep: cover property (mode == 3'h1);
  c_settled: cover property ($past(mode) == 3'h5 && mode == 3'h0);
  c_sub: cover property (mode == 3'h4);
endmodule
`default_nettype wire

// ---- test/cpu_intc_model.sv ----
/*
  Model of the CPU core, interrupt controller and reset pin around the
  sequencer. Levels change just after a rising edge of aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cpu_intc_model (
  input wire logic aclk,
  output logic halt_exec,
  output logic timebase_watch_select,
  output logic interrupt_mask_flag,
  output logic irq_zero_enable,
  output logic irq_one_enable,
  output logic timer_a_enable,
  output logic direct_irq_enable,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic timer_a_request,
  output logic external_reset_n
);
  // Quiet after power-up: masked, nothing requested, pin high
  initial begin
    {halt_exec, timebase_watch_select, ext_irq_zero, ext_irq_one, timer_a_request} = 5'h00;
    {irq_zero_enable, irq_one_enable, timer_a_enable, direct_irq_enable} = 4'h0;
    interrupt_mask_flag = 1'b1;
    external_reset_n = 1'b1;
  end
  // Sets the wake-source enables and the mask flag before a low-power entry
  task automatic arm(input logic [3:0] en, input logic m);
    @(posedge aclk);
    {irq_zero_enable, irq_one_enable, timer_a_enable, direct_irq_enable} <= en;
    interrupt_mask_flag <= m;
  endtask
  // One-cycle halt instruction
  task automatic halt(input logic tw);
    @(posedge aclk);
    timebase_watch_select <= tw;
    halt_exec <= 1'b1;
    @(posedge aclk);
    halt_exec <= 1'b0;
  endtask
  task automatic req(input logic [2:0] v);
    @(posedge aclk);
    {ext_irq_zero, ext_irq_one, timer_a_request} <= v;
  endtask
  // Caller keeps the pin low for 21 cycles after the mode returns to active
  task automatic pin(input logic v);
    @(posedge aclk);
    external_reset_n <= v;
  endtask
endmodule
`default_nettype wire

// ---- test/low_power_mode_sequencer_tb.sv ----
/*
  Self-checking bench of the power-mode sequencer: AXI4-Lite registers,
  every mode and a wake path out of each, settling count. CPU side is cpu_intc_model.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module low_power_mode_sequencer_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic halt_exec, timebase_watch_select, interrupt_mask_flag, irq_zero_enable, irq_one_enable;
  logic timer_a_enable, direct_irq_enable, ext_irq_zero, ext_irq_one, timer_a_request, external_reset_n;
  logic main_osc_enable, cpu_clock_enable, cpu_on_subclock, cpu_reset, peripheral_enable, timer_a_run;
  logic ext_irq_run, peripheral_out_reset, ports_high_z, pmos_off, irq_exception_start, direct_transfer_irq;
  logic [2:0] mode;
  int n_mismatch = 0;
  int n_tests = 0;
  int c;
  power_mode_sequencer i_power_mode_sequencer (.*);
  cpu_intc_model i_cpu_intc_model (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One access; address and data offered together, ready seen before the edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tr, tk;
    logic [1:0] rsp;
    logic [31:0] rd;
    int i;
    @(posedge aclk);
    s_axi_wstrb <= 4'h1 | 4'($urandom);
    if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    for (i = 0; i < 40; i++) begin
      @(negedge aclk);
      {ta, tw, tr} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_arvalid & s_axi_arready};
      tk = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
      {rsp, rd} = {wr ? s_axi_bresp : s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (tk) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (i == 40) begin n_mismatch++; final_report; end
    `CHK("resp", er, rsp)
    if (!wr && er == 2'h0) `CHK("rdata", d, rd)
  endtask
  // Bounded wait for a mode; c holds the cycles it took
  task automatic wait_mode(input logic [2:0] m, input int lim);
    c = 0;
    while (mode !== m) begin
      @(posedge aclk);
      #1;
      c++;
      if (c > lim) begin n_mismatch++; final_report; end
    end
  endtask
  // Pin low forces active with CPU held; pin high again lets it run
  task automatic reset_exit;
    i_cpu_intc_model.pin(1'b0);
    wait_mode(3'h0, 6);
    `CHK("cpu_reset", 1'b1, cpu_reset)
    repeat (20) @(posedge aclk);
    i_cpu_intc_model.pin(1'b1);
    for (c = 0; c < 8 && cpu_reset !== 1'b0; c++) begin @(posedge aclk); #1; end
    `CHK("cpu_release", 1'b0, cpu_reset)
  endtask
  task automatic hold_check(input logic [2:0] m);
    repeat (8) @(posedge aclk);
    #1;
    `CHK("mode", m, mode)
  endtask
  initial begin
    void'($urandom(32'h0a66_1be9));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {12'h00f, 32'h0000_0000};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, write refused outside subactive, bus errors
    xfer(1'b0, 4'h0, 32'h0000_0000, 2'h0);
    xfer(1'b1, 4'h4, 32'h0000_000b, 2'h0);
    xfer(1'b0, 4'h4, 32'h0000_00f4, 2'h0);
    xfer(1'b0, 4'h8, 32'h0000_0000, 2'h0);
    xfer(1'b1, 4'h8, 32'h0000_0000, 2'h2);
    xfer(1'b0, 4'hc, 32'h0000_0000, 2'h2);
    // Sleep: masked request ignored, unmasked one wakes
    r = $urandom & 32'h0000_0004;
    xfer(1'b1, 4'h0, r, 2'h0);
    xfer(1'b0, 4'h0, r, 2'h0);
    i_cpu_intc_model.arm(4'h8, 1'b1);
    i_cpu_intc_model.halt(1'b0);
    wait_mode(3'h1, 4);
    i_cpu_intc_model.req(3'h4);
    hold_check(3'h1);
    i_cpu_intc_model.arm(4'h8, 1'b0);
    wait_mode(3'h0, 6);
    `CHK("exc_sleep", 1'b1, irq_exception_start)
    i_cpu_intc_model.req(3'h0);
    i_cpu_intc_model.halt(1'b0);
    wait_mode(3'h1, 4);
    reset_exit;
    // Standby, woken by irq one after the full settling wait
    r = $urandom & 32'h0000_0004;
    xfer(1'b1, 4'h0, 32'h0000_0080 | r, 2'h0);
    i_cpu_intc_model.arm(4'h4, 1'b0);
    i_cpu_intc_model.halt(1'b0);
    wait_mode(3'h2, 4);
    @(posedge aclk);
    #1;
    `CHK("standby_pins", 4'hd, {ports_high_z, pmos_off, main_osc_enable, ext_irq_run})
    i_cpu_intc_model.req(3'h2);
    wait_mode(3'h5, 6);
    wait_mode(3'h0, 140000);
    `CHK("settle", 32'h0000_2001, c)
    `CHK("exc_standby", 1'b1, irq_exception_start)
    i_cpu_intc_model.req(3'h0);
    xfer(1'b0, 4'h0, 32'h0000_0080 | r, 2'h0);
    // Watch: irq one refused, timer A wakes through settling
    i_cpu_intc_model.arm(4'h6, 1'b0);
    i_cpu_intc_model.halt(1'b1);
    wait_mode(3'h3, 4);
    i_cpu_intc_model.req(3'h2);
    hold_check(3'h3);
    `CHK("watch_clk", 3'h2, {main_osc_enable, timer_a_run, peripheral_enable})
    i_cpu_intc_model.req(3'h1);
    wait_mode(3'h5, 6);
    wait_mode(3'h0, 140000);
    `CHK("exc_watch", 1'b1, irq_exception_start)
    i_cpu_intc_model.req(3'h0);
    // Watch to subactive on irq zero; low speed set, so halt goes to watch
    xfer(1'b1, 4'h0, 32'h0000_0088, 2'h0);
    i_cpu_intc_model.arm(4'h8, 1'b0);
    i_cpu_intc_model.halt(1'b1);
    wait_mode(3'h3, 4);
    i_cpu_intc_model.req(3'h4);
    wait_mode(3'h4, 6);
    i_cpu_intc_model.req(3'h0);
    #1;
    `CHK("sub_clk", 3'h7, {cpu_on_subclock, peripheral_out_reset, cpu_clock_enable})
    r = $urandom & 32'h0000_000b;
    xfer(1'b1, 4'h4, r, 2'h0);
    xfer(1'b0, 4'h4, 32'h0000_00f4 | r, 2'h0);
    i_cpu_intc_model.halt(1'b1);
    wait_mode(3'h3, 4);
    reset_exit;
    // Direct transfer: low speed cleared in subactive, halt settles into active
    i_cpu_intc_model.halt(1'b1);
    wait_mode(3'h3, 4);
    i_cpu_intc_model.req(3'h4);
    wait_mode(3'h4, 6);
    i_cpu_intc_model.req(3'h0);
    xfer(1'b1, 4'h4, 32'h0000_0008, 2'h0);
    xfer(1'b1, 4'h0, 32'h0000_0080, 2'h0);
    i_cpu_intc_model.arm(4'h9, 1'b0);
    i_cpu_intc_model.halt(1'b1);
    #1;
    wait_mode(3'h5, 6);
    `CHK("direct_irq", 1'b1, direct_transfer_irq)
    wait_mode(3'h0, 140000);
    `CHK("exc_direct", 1'b0, irq_exception_start)
    final_report;
  end
endmodule
bind power_mode_sequencer power_mode_sequencer_assertions i_power_mode_sequencer_assertions (.*);
`default_nettype wire
